// [logic/dbg_port_regs.svh]
`ifndef DBG_PORT_REGS_SVH
`define DBG_PORT_REGS_SVH
// TAP instruction register
`define IR_WIDTH        4
`define IR_RESET_VAL    4'h1
`define IR_BYPASS       4'hf
`define IR_IDCODE       4'h1
`define IR_DBGCTL       4'h8
// Debug control register layout (loaded through the scan chain)
`define DCTL_WIDTH      4
`define DCTL_RESET_VAL  4'h0
`define DCTL_BR_TRACE   0
`define DCTL_TRIG_EN    1
`define DCTL_TRIG_MODE  2
`define DCTL_BREAK_SW   3
// Identity value, arbitrary
`define ID_VALUE        32'h0000_1001
`endif

// [logic/dbg_port_pkg.sv]
package dbg_port_pkg;
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
    TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } tap_state_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } tap_pins_t;

  typedef struct packed {
    logic sdram_rd;
    logic sdram_wr;
    logic code_fetch;
    logic src_cpu;
    logic src_pci;
    logic src_dma;
    logic gp_memory_read_strobe;
    logic boot_memory_read_strobe;
    logic rom_or_cs_fetch;
    logic sdram_data_valid;
  } mem_status_t;
endpackage : dbg_port_pkg

// [logic/pin_sync.sv]
`timescale 1ns/1ps
module pin_sync #(
  parameter int          WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             clock, // System clock
  input  wire logic             rst,   // Async reset
  input  wire logic [WIDTH-1:0] d,     // Asynchronous inputs
  output logic      [WIDTH-1:0] q      // Synchronised outputs
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] q_ff;

  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      meta_ff <= INIT;
      q_ff    <= INIT;
    end
    else
    begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end

  assign q = q_ff;
endmodule : pin_sync

// [logic/tap_fsm.sv]
`timescale 1ns/1ps
module tap_fsm
  import dbg_port_pkg::*;
(
  input  wire logic       clock,    // System clock
  input  wire logic       rst,      // Async reset
  input  wire logic       tap_rst,  // Synchronous TAP reset
  input  wire logic       tck_rise, // Test clock rising edge
  input  wire logic       tms,      // Synced mode select
  output dbg_port_pkg::tap_state_t state // Current TAP state
);
  tap_state_t state_ff;
  tap_state_t nxt_state;

  // ----------------------------------------------------------------
  // Standard state sequence
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      TAP_RESET:    nxt_state = tms ? TAP_RESET    : TAP_IDLE;
      TAP_IDLE:     nxt_state = tms ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_DR:   nxt_state = tms ? TAP_SEL_IR   : TAP_CAP_DR;
      TAP_CAP_DR:   nxt_state = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: nxt_state = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: nxt_state = tms ? TAP_UPD_DR   : TAP_PAUSE_DR;
      TAP_PAUSE_DR: nxt_state = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: nxt_state = tms ? TAP_UPD_DR   : TAP_SHIFT_DR;
      TAP_UPD_DR:   nxt_state = tms ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_IR:   nxt_state = tms ? TAP_RESET    : TAP_CAP_IR;
      TAP_CAP_IR:   nxt_state = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: nxt_state = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: nxt_state = tms ? TAP_UPD_IR   : TAP_PAUSE_IR;
      TAP_PAUSE_IR: nxt_state = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: nxt_state = tms ? TAP_UPD_IR   : TAP_SHIFT_IR;
      TAP_UPD_IR:   nxt_state = tms ? TAP_SEL_DR   : TAP_IDLE;
      default:      nxt_state = TAP_RESET;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
    if (rst)
      state_ff <= TAP_RESET;
    else if (tap_rst)
      state_ff <= TAP_RESET;
    else if (tck_rise)
      state_ff <= nxt_state;

  assign state = state_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_tap_held_reset;
    @(posedge clock) disable iff (rst) tap_rst |=> state_ff == TAP_RESET;
  endproperty
  a_tap_held_reset: assert property (p_tap_held_reset)
    else $error("TAP left reset while test reset active");

  property p_tap_five_ones;
    @(posedge clock) disable iff (rst)
      (tck_rise && tms && !tap_rst && state_ff == TAP_SEL_IR) |=> state_ff == TAP_RESET;
  endproperty
  a_tap_five_ones: assert property (p_tap_five_ones)
    else $error("TAP did not return to reset from select IR");

  property p_tap_hold_no_edge;
    @(posedge clock) disable iff (rst) (!tck_rise && !tap_rst) |=> $stable(state_ff);
  endproperty
  a_tap_hold_no_edge: assert property (p_tap_hold_no_edge)
    else $error("TAP moved without a test clock rise");
endmodule : tap_fsm

// [logic/debug_test_status_port.sv]
`timescale 1ns/1ps
`include "dbg_port_regs.svh"
module debug_test_status_port
  import dbg_port_pkg::*;
(
  input  wire logic                    clock,                   // System clock 100 MHz
  input  wire logic                    rst,                     // Async reset, active high
  input  wire dbg_port_pkg::tap_pins_t tap_pins,                // Test clock, mode, data, reset
  input  wire logic                    tms_driven,              // Mode select has a driver
  input  wire logic                    tdi_driven,              // Data input has a driver
  input  wire logic                    trst_driven,             // Test reset has a driver
  output logic                         tdo_o,                   // Test data output value
  output logic                         tdo_oe,                  // Test data output enable
  input  wire logic                    break_req_trace_ctl,     // Break request or trace control pin
  output logic                         command_done_ack,        // Ready for next command
  output logic                         stop_tx,                 // Stop/transmit
  output logic                         trigger_trace_out,       // Trigger or trace status
  output logic                         debug_mode,              // Core held in debug mode
  input  wire logic                    cmd_start,               // Emulator starts a command
  input  wire logic                    cmd_done,                // Emulator command finished
  input  wire logic                    resume,                  // Leave debug mode
  input  wire logic                    tx_pending,              // Data waiting for host
  input  wire logic                    trigger_event,           // Debug register trigger hit
  input  wire dbg_port_pkg::mem_status_t mem_status,            // Memory cycle status
  output logic                         sdram_code_fetch_flag,   // SDRAM fetch/source flag
  output logic                         rom_cs_code_fetch_flag,  // ROM/chip-select fetch flag
  output logic                         sdram_data_latch_strobe, // Data latch strobe
  output logic                         trace_on                 // Trace capture status
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Driven flags are pins too, so pulls apply only after the flops
  logic [7:0] sync_q;
  pin_sync #(.WIDTH(8), .INIT(8'h77)) u_sync (
    .clock (clock),
    .rst   (rst),
    .d     ({tap_pins.tck, tap_pins.tms, tap_pins.tdi, tap_pins.trst_n, break_req_trace_ctl,
             tms_driven, tdi_driven, trst_driven}),
    .q     (sync_q)
  );
  wire tck_s  = sync_q[7];
  wire tms_s  = sync_q[2] ? sync_q[6] : 1'b1;
  wire tdi_s  = sync_q[1] ? sync_q[5] : 1'b1;
  wire trst_s = sync_q[0] ? sync_q[4] : 1'b0;
  wire brk_s  = sync_q[3];

  logic tck_d_ff;
  logic brk_d_ff;
  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      tck_d_ff <= 1'b0;
      brk_d_ff <= 1'b0;
    end
    else
    begin
      tck_d_ff <= tck_s;
      brk_d_ff <= brk_s;
    end

  wire tck_rise = tck_s & ~tck_d_ff;
  wire tck_fall = ~tck_s & tck_d_ff;
  wire brk_rise = brk_s & ~brk_d_ff;
  wire tap_rst  = ~trst_s;

  // ----------------------------------------------------------------
  // TAP controller
  // ----------------------------------------------------------------
  tap_state_t state;
  tap_fsm u_fsm (
    .clock    (clock),
    .rst      (rst),
    .tap_rst  (tap_rst),
    .tck_rise (tck_rise),
    .tms      (tms_s),
    .state    (state)
  );

  wire in_shift_dr = (state == TAP_SHIFT_DR);
  wire in_shift_ir = (state == TAP_SHIFT_IR);

  logic [`IR_WIDTH-1:0]   ir_ff;
  logic [`IR_WIDTH-1:0]   ir_sr_ff;
  logic [31:0]            dr_sr_ff;
  logic [`DCTL_WIDTH-1:0] dctl_ff;

  wire sel_id   = (ir_ff == `IR_IDCODE);
  wire sel_dctl = (ir_ff == `IR_DBGCTL);
  wire [31:0] dr_capture = sel_id   ? `ID_VALUE :
                           sel_dctl ? {28'h0, dctl_ff} : 32'h0;
  // Bypass and control use the low bits; the selected instruction sets the window
  wire [31:0] dr_shifted = sel_id   ? {tdi_s, dr_sr_ff[31:1]} :
                           sel_dctl ? {28'h0, tdi_s, dr_sr_ff[3:1]} :
                                      {31'h0, tdi_s};

  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      ir_ff    <= `IR_RESET_VAL;
      ir_sr_ff <= `IR_RESET_VAL;
      dr_sr_ff <= 32'h0;
      dctl_ff  <= `DCTL_RESET_VAL;
    end
    else if (tap_rst || (state == TAP_RESET))
    begin
      ir_ff    <= `IR_RESET_VAL;
      ir_sr_ff <= `IR_RESET_VAL;
      dctl_ff  <= `DCTL_RESET_VAL;
    end
    else if (tck_rise)
    begin
      case (state)
        TAP_CAP_IR:   ir_sr_ff <= `IR_RESET_VAL;
        TAP_SHIFT_IR: ir_sr_ff <= {tdi_s, ir_sr_ff[`IR_WIDTH-1:1]};
        TAP_UPD_IR:   ir_ff    <= ir_sr_ff;
        TAP_CAP_DR:   dr_sr_ff <= dr_capture;
        TAP_SHIFT_DR: dr_sr_ff <= dr_shifted;
        TAP_UPD_DR:   if (sel_dctl) dctl_ff <= dr_sr_ff[`DCTL_WIDTH-1:0];
        default:      dctl_ff  <= dctl_ff;
      endcase
    end

  // ----------------------------------------------------------------
  // Test data output
  // ----------------------------------------------------------------
  logic tdo_ff;
  logic tdo_oe_ff;
  wire  tdo_bit = in_shift_ir ? ir_sr_ff[0] : dr_sr_ff[0];

  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      tdo_ff    <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end
    else if (tap_rst)
    begin
      tdo_ff    <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo_ff    <= tdo_bit;
      tdo_oe_ff <= in_shift_dr | in_shift_ir;
    end

  assign tdo_o  = tdo_ff;
  assign tdo_oe = tdo_oe_ff;

  // ----------------------------------------------------------------
  // Debug handshake
  // ----------------------------------------------------------------
  logic debug_mode_ff;
  logic ready_ff;
  logic trace_ff;
  logic stop_ff;
  logic trig_ff;

  wire brk_as_trace = dctl_ff[`DCTL_BR_TRACE];
  wire enter_dbg = (brk_rise & ~brk_as_trace) | (dctl_ff[`DCTL_BREAK_SW] & ~debug_mode_ff);

  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      debug_mode_ff <= 1'b0;
      ready_ff      <= 1'b1;
      trace_ff      <= 1'b0;
    end
    else
    begin
      if (enter_dbg)
        debug_mode_ff <= 1'b1;
      else if (resume && ready_ff)
        debug_mode_ff <= 1'b0;
      if (cmd_start && ready_ff)
        ready_ff <= 1'b0;
      else if (cmd_done)
        ready_ff <= 1'b1;
      if (brk_rise && brk_as_trace)
        trace_ff <= ~trace_ff;
    end

  wire nxt_stop = debug_mode_ff | enter_dbg | tx_pending;
  wire nxt_trig = ~dctl_ff[`DCTL_TRIG_EN] ? 1'b0 :
                  dctl_ff[`DCTL_TRIG_MODE] ? trace_ff : trigger_event;

  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      stop_ff <= 1'b0;
      trig_ff <= 1'b0;
    end
    else
    begin
      stop_ff <= nxt_stop;
      trig_ff <= nxt_trig;
    end

  assign command_done_ack  = ready_ff;
  assign stop_tx           = stop_ff;
  assign trigger_trace_out = trig_ff;
  assign debug_mode        = debug_mode_ff;
  assign trace_on          = trace_ff;

  // ----------------------------------------------------------------
  // System test status
  // ----------------------------------------------------------------
  // read fetch; write source
  wire nxt_sdram_cf = mem_status.sdram_rd ? ~mem_status.code_fetch :
                      mem_status.sdram_wr ? (mem_status.src_dma | mem_status.src_pci) : 1'b1;
  wire rom_rd     = mem_status.gp_memory_read_strobe | mem_status.boot_memory_read_strobe;
  wire nxt_rom_cf = ~(rom_rd & mem_status.rom_or_cs_fetch);

  logic sdram_cf_ff;
  logic rom_cf_ff;
  logic strobe_ff;
  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      sdram_cf_ff <= 1'b1;
      rom_cf_ff   <= 1'b1;
      strobe_ff   <= 1'b0;
    end
    else
    begin
      sdram_cf_ff <= nxt_sdram_cf;
      rom_cf_ff   <= nxt_rom_cf;
      strobe_ff   <= mem_status.sdram_data_valid;
    end

  assign sdram_code_fetch_flag   = sdram_cf_ff;
  assign rom_cs_code_fetch_flag  = rom_cf_ff;
  assign sdram_data_latch_strobe = strobe_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_tdo_float;
    @(posedge clock) disable iff (rst)
      (tck_fall && !in_shift_dr && !in_shift_ir) |=> !tdo_oe;
  endproperty
  a_tdo_float: assert property (p_tdo_float)
    else $error("Data output driven outside shift");

  property p_ack_low_busy;
    @(posedge clock) disable iff (rst)
      (cmd_start && command_done_ack && !cmd_done) |=> !command_done_ack;
  endproperty
  a_ack_low_busy: assert property (p_ack_low_busy)
    else $error("Acknowledge not low after command start");

  property p_ack_back;
    @(posedge clock) disable iff (rst) (cmd_done && !command_done_ack) |=> command_done_ack;
  endproperty
  a_ack_back: assert property (p_ack_back)
    else $error("Acknowledge not high after completion");

  property p_break_stop;
    @(posedge clock) disable iff (rst)
      (brk_rise && !brk_as_trace) |=> (debug_mode && stop_tx);
  endproperty
  a_break_stop: assert property (p_break_stop)
    else $error("Break did not raise debug mode and stop");

  property p_tx_stop;
    @(posedge clock) disable iff (rst) tx_pending |=> stop_tx;
  endproperty
  a_tx_stop: assert property (p_tx_stop)
    else $error("Stop/transmit low with data pending");

  property p_trace_toggle;
    @(posedge clock) disable iff (rst)
      (brk_rise && brk_as_trace) |=> (trace_on != $past(trace_on) && !$changed(debug_mode));
  endproperty
  a_trace_toggle: assert property (p_trace_toggle)
    else $error("Trace capture did not toggle");

  property p_sdram_read;
    @(posedge clock) disable iff (rst)
      mem_status.sdram_rd |=> sdram_code_fetch_flag == !$past(mem_status.code_fetch);
  endproperty
  a_sdram_read: assert property (p_sdram_read)
    else $error("SDRAM fetch flag wrong on read");

  property p_sdram_write;
    @(posedge clock) disable iff (rst)
      (mem_status.sdram_wr && !mem_status.sdram_rd && mem_status.src_cpu
       && !mem_status.src_pci && !mem_status.src_dma) |=> !sdram_code_fetch_flag;
  endproperty
  a_sdram_write: assert property (p_sdram_write)
    else $error("SDRAM flag high on processor only write");

  property p_rom_high;
    @(posedge clock) disable iff (rst)
      !(mem_status.gp_memory_read_strobe || mem_status.boot_memory_read_strobe)
      |=> rom_cs_code_fetch_flag;
  endproperty
  a_rom_high: assert property (p_rom_high)
    else $error("ROM fetch flag low outside read");

  c_break:  cover property (@(posedge clock) disable iff (rst) brk_rise ##[1:4] debug_mode);
  c_cmd:    cover property (@(posedge clock) disable iff (rst)
                            !command_done_ack ##[1:20] command_done_ack);
  c_shift:  cover property (@(posedge clock) disable iff (rst) tdo_oe);
  c_romcf:  cover property (@(posedge clock) disable iff (rst) !rom_cs_code_fetch_flag);
endmodule : debug_test_status_port

// [bench/jtag_host_model.sv]
`timescale 1ns/1ps
// ----
// Emulator side of the test port
// ----
module jtag_host_model (
  input  wire logic              tdo_o,       // Device test data
  input  wire logic              tdo_oe,      // Device drives test data
  output dbg_port_pkg::tap_pins_t pins,       // Test clock, mode, data, reset
  output logic                   tms_driven,  // Mode select driven
  output logic                   tdi_driven,  // Data input driven
  output logic                   trst_driven  // Test reset driven
);
  import dbg_port_pkg::*;

  initial
  begin
    pins = 4'b0111;
    tms_driven = 1'b1;
    tdi_driven = 1'b1;
    trst_driven = 1'b1;
  end

  // released reset keeps its high level, so only the pull can reset
  task automatic set_drive(input logic m, input logic d, input logic r);
    tms_driven = m;
    tdi_driven = d;
    trst_driven = r;
  endtask : set_drive

  task automatic cyc(input logic m, input logic d, output logic q, output logic oe);
    // Released mode and data lines flip so a stale level never passes
    pins.tms <= tms_driven ? m : ~pins.tms;
    pins.tdi <= tdi_driven ? d : ~pins.tdi;
    #80;
    pins.tck <= 1'b1;
    q = tdo_o;
    oe = tdo_oe;
    #80;
    pins.tck <= 1'b0;
  endtask : cyc

  // five ones reach reset, then idle
  task automatic go_reset();
    logic q;
    logic oe;
    repeat (5) cyc(1'b1, 1'b1, q, oe);
    cyc(1'b0, 1'b1, q, oe);
  endtask : go_reset

  // idle to shift, n bits lsb first, back to idle
  task automatic scan(input logic ir, input logic [31:0] din, input int n,
                      output logic [31:0] dout, output int oe_cnt);
    logic q;
    logic oe;
    dout = '0;
    oe_cnt = 0;
    cyc(1'b1, 1'b1, q, oe);
    if (ir)
      cyc(1'b1, 1'b1, q, oe);
    cyc(1'b0, 1'b1, q, oe);
    cyc(1'b0, 1'b1, q, oe);
    for (int i = 0; i < n; i++)
    begin
      cyc(i == n - 1, din[i], q, oe);
      dout[i] = q;
      oe_cnt += int'(oe === 1'b1);
    end
    cyc(1'b1, 1'b1, q, oe);
    cyc(1'b0, 1'b1, q, oe);
  endtask : scan
endmodule : jtag_host_model

// [bench/test_debug_test_status_port.sv]
`timescale 1ns/1ps
`include "dbg_port_regs.svh"
module test_debug_test_status_port;
  import dbg_port_pkg::*;

  logic        clock;
  logic        rst;
  tap_pins_t   pins;
  logic        tms_dr;
  logic        tdi_dr;
  logic        trst_dr;
  logic        tdo;
  logic        tdo_oe;
  logic        brk;
  logic        ack;
  logic        stop_tx;
  logic        trig;
  logic        dbg;
  logic        cmd_start;
  logic        cmd_done;
  logic        resume;
  logic        tx_pending;
  logic        trig_ev;
  mem_status_t mem_st;
  logic        sd_flag;
  logic        rom_flag;
  logic        strobe;
  logic        trace_on;
  int          failures;
  int          checked;
  logic [31:0] dout;
  int          oe_cnt;

  debug_test_status_port dut (
    .clock(clock), .rst(rst), .tap_pins(pins), .tms_driven(tms_dr), .tdi_driven(tdi_dr),
    .trst_driven(trst_dr), .tdo_o(tdo), .tdo_oe(tdo_oe), .break_req_trace_ctl(brk),
    .command_done_ack(ack), .stop_tx(stop_tx), .trigger_trace_out(trig), .debug_mode(dbg),
    .cmd_start(cmd_start), .cmd_done(cmd_done), .resume(resume), .tx_pending(tx_pending),
    .trigger_event(trig_ev), .mem_status(mem_st), .sdram_code_fetch_flag(sd_flag),
    .rom_cs_code_fetch_flag(rom_flag), .sdram_data_latch_strobe(strobe), .trace_on(trace_on)
  );

  jtag_host_model host (
    .tdo_o(tdo), .tdo_oe(tdo_oe), .pins(pins), .tms_driven(tms_dr), .tdi_driven(tdi_dr),
    .trst_driven(trst_dr)
  );

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic wrap_up();
    $display("Counts: %0d checked, %0d failures", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask : chk

  // Bounded wait; running out ends the run
  task automatic wait_on(ref logic s, input logic v, input string what);
    #1;
    for (int n = 0; n < 24 && s !== v; n++)
    begin
      @(posedge clock);
      #1;
    end
    chk(s, v, what);
    if (s !== v)
      wrap_up();
  endtask : wait_on

  // Host traffic starts off the clock edge
  task automatic scan(input logic ir, input logic [31:0] din, input int n);
    @(posedge clock);
    #3;
    host.scan(ir, din, n, dout, oe_cnt);
  endtask : scan

  task automatic t_status();
    mem_status_t m;
    logic        e_sd;
    logic        e_rom;
    for (int i = 0; i < 1024; i++)
    begin
      m = mem_status_t'(i[9:0]);
      if (m.sdram_rd && m.sdram_wr)
        continue;
      @(posedge clock);
      mem_st <= m;
      @(posedge clock);
      #1;
      e_sd = m.sdram_rd ? !m.code_fetch : (m.sdram_wr ? (m.src_dma | m.src_pci) : 1'b1);
      chk(sd_flag, e_sd, "sdram fetch flag");
      e_rom = !((m.gp_memory_read_strobe | m.boot_memory_read_strobe) & m.rom_or_cs_fetch);
      chk(rom_flag, e_rom, "rom fetch flag");
      chk(strobe, m.sdram_data_valid, "data strobe");
    end
    $display("status flags done");
  endtask : t_status

  task automatic t_cmd();
    @(posedge clock);
    cmd_start <= 1'b1;
    @(posedge clock);
    cmd_start <= 1'b0;
    #1;
    chk(ack, 1'b0, "ack low on start");
    @(posedge clock);
    cmd_start <= 1'b1;
    @(posedge clock);
    cmd_start <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    chk(ack, 1'b0, "ack held while busy");
    @(posedge clock);
    cmd_done <= 1'b1;
    @(posedge clock);
    cmd_done <= 1'b0;
    #1;
    chk(ack, 1'b1, "ack on completion");
    repeat (2) @(posedge clock);
    #1;
    chk(ack, 1'b1, "busy start dropped");
    $display("command handshake done");
  endtask : t_cmd

  task automatic t_break();
    @(posedge clock);
    brk <= 1'b1;
    wait_on(dbg, 1'b1, "debug entry");
    chk(stop_tx, 1'b1, "stop on entry");
    @(posedge clock);
    brk <= 1'b0;
    resume <= 1'b1;
    @(posedge clock);
    resume <= 1'b0;
    wait_on(dbg, 1'b0, "debug exit");
    @(posedge clock);
    #1;
    chk(stop_tx, 1'b0, "stop idle");
    @(posedge clock);
    tx_pending <= 1'b1;
    wait_on(stop_tx, 1'b1, "tx pending");
    @(posedge clock);
    tx_pending <= 1'b0;
    wait_on(stop_tx, 1'b0, "tx cleared");
    $display("break done");
  endtask : t_break

  task automatic t_scan();
    logic q;
    logic oe;
    host.go_reset();
    scan(1'b0, 32'h0, 32);
    chk(dout === `ID_VALUE, 1'b1, "identity value");
    chk(oe_cnt == 32, 1'b1, "drive while shifting");
    chk(tdo_oe, 1'b0, "float when idle");
    host.set_drive(1'b1, 1'b0, 1'b1);
    scan(1'b1, 32'h0, 4);
    scan(1'b0, 32'h0, 4);
    chk(dout[3:1] === 3'b111, 1'b1, "undriven data high");
    host.set_drive(1'b0, 1'b1, 1'b1);
    host.go_reset();
    host.set_drive(1'b1, 1'b1, 1'b1);
    host.cyc(1'b0, 1'b1, q, oe);
    scan(1'b0, 32'h0, 32);
    chk(dout === `ID_VALUE, 1'b1, "undriven mode resets");
    host.set_drive(1'b1, 1'b1, 1'b0);
    scan(1'b0, 32'h0, 32);
    chk(oe_cnt == 0, 1'b1, "held in reset");
    host.set_drive(1'b1, 1'b1, 1'b1);
    host.pins.trst_n <= 1'b0;
    scan(1'b0, 32'h0, 32);
    chk(oe_cnt == 0, 1'b1, "held by low reset");
    host.pins.trst_n <= 1'b1;
    host.go_reset();
    $display("scan port done");
  endtask : t_scan

  task automatic t_trace();
    scan(1'b1, 32'(`IR_DBGCTL), 4);
    scan(1'b0, 32'h7, 4);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clock);
      brk <= 1'b1;
      wait_on(trace_on, k == 0, "trace toggle");
      wait_on(trig, k == 0, "trace status out");
      chk(dbg, 1'b0, "no debug entry");
      @(posedge clock);
      brk <= 1'b0;
      repeat (4) @(posedge clock);
    end
    scan(1'b0, 32'h2, 4);
    @(posedge clock);
    trig_ev <= 1'b1;
    wait_on(trig, 1'b1, "trigger out");
    @(posedge clock);
    trig_ev <= 1'b0;
    wait_on(trig, 1'b0, "trigger clear");
    scan(1'b0, 32'h0, 4);
    scan(1'b0, 32'h8, 4);
    wait_on(dbg, 1'b1, "software break");
    chk(stop_tx, 1'b1, "stop on software break");
    scan(1'b0, 32'h0, 4);
    @(posedge clock);
    resume <= 1'b1;
    @(posedge clock);
    resume <= 1'b0;
    wait_on(dbg, 1'b0, "software break exit");
    $display("trace control done");
  endtask : t_trace

  initial
  begin
    failures = 0;
    checked = 0;
    rst = 1'b1;
    {brk, cmd_start, cmd_done, resume, tx_pending, trig_ev} = '0;
    mem_st = '0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    chk(ack, 1'b1, "ack after reset");
    chk(rom_flag, 1'b1, "rom flag after reset");
    chk(tdo_oe, 1'b0, "tdo float after reset");
    $display("reset done");
    t_status();
    t_cmd();
    t_break();
    t_scan();
    t_trace();
    wrap_up();
  end
endmodule : test_debug_test_status_port
